/* csup_supervisor.sv */
`timescale 1ns/1ns
`default_nettype none
module csup_supervisor #(
   parameter int unsigned TICK_CYC = csup_pkg::TICK_CYC
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // Avalon-MM slave
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Measurement path
   input wire logic [csup_pkg::CW-1:0] conc_i,
   input wire logic conc_vld_i,
   input wire logic [csup_pkg::SW-1:0] raw_sens_i,
   output logic [csup_pkg::CW-1:0] cal_span_o,
   // Relays and indicators
   output logic first_conc_alarm_relay_o,
   output logic second_conc_alarm_relay_o,
   output logic sys_alarm_relay_o,
   output logic span_fail_flag_o,
   output logic span_fail_show_o,
   output logic span_active_o
);
   typedef struct packed {
      logic wait_r;
      logic [31:0] rdata;
      logic [3:0] cfg1;
      logic [csup_pkg::CW-1:0] sp1;
      logic [3:0] cfg2;
      logic [csup_pkg::CW-1:0] sp2;
      logic auto_mode;
      logic [5:0] hold_min;
      logic [csup_pkg::CW-1:0] gas;
      logic [csup_pkg::CW-1:0] tol;
      csup_pkg::csup_span_st_t st;
      logic [csup_pkg::CW-1:0] cal;
      logic [csup_pkg::CW-1:0] cal_prev;
      logic [csup_pkg::CW-1:0] prev_smp;
      logic [csup_pkg::CW-1:0] last_smp;
      logic [csup_pkg::CW:0] slope;
      logic [11:0] sec_cnt;
      logic fail_flag;
      logic sys_relay;
      logic busy;
      logic show;
   } csup_state_t;

   localparam csup_state_t S_RST = '{
      wait_r: 1'b1,
      rdata: 32'h0,
      cfg1: csup_pkg::ALM_CFG_RST,
      sp1: csup_pkg::SP_RST,
      cfg2: csup_pkg::ALM_CFG_RST,
      sp2: csup_pkg::SP_RST,
      auto_mode: 1'b1,
      hold_min: csup_pkg::HOLD_MIN_DEF,
      gas: csup_pkg::GAS_RST,
      tol: csup_pkg::TOL_RST,
      st: csup_pkg::ST_IDLE,
      cal: csup_pkg::CAL_RST,
      cal_prev: csup_pkg::CAL_RST,
      prev_smp: 24'h0,
      last_smp: 24'h0,
      slope: 25'h0,
      sec_cnt: 12'h0,
      fail_flag: 1'b0,
      sys_relay: 1'b1,
      busy: 1'b0,
      show: 1'b0
   };

   logic [1:0] rst_q;
   logic rst_n;
   csup_state_t s_r;
   csup_state_t s_nxt;
   logic tick;
   logic alarm1;
   logic alarm2;

   // Reset release through two flip-flops
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         rst_q <= 2'b00;
      else
         rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   // Concentration alarms
   csup_alarm_unit u_first_conc_alarm (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n),
      .cfg_i(s_r.cfg1),
      .setpoint_i(s_r.sp1),
      .conc_i(conc_i),
      .conc_vld_i(conc_vld_i),
      .alarm_o(alarm1),
      .relay_o(first_conc_alarm_relay_o)
   );

   csup_alarm_unit u_second_conc_alarm (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n),
      .cfg_i(s_r.cfg2),
      .setpoint_i(s_r.sp2),
      .conc_i(conc_i),
      .conc_vld_i(conc_vld_i),
      .alarm_o(alarm2),
      .relay_o(second_conc_alarm_relay_o)
   );

   // Span sample and seconds timebase
   csup_tick #(
      .CYC(TICK_CYC)
   ) u_tick (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n),
      .en_i(s_r.busy),
      .tick_o(tick)
   );

   always_comb
   begin
      logic wr_go;
      logic start_wr;
      logic conf_wr;
      logic near;
      logic [5:0] hm;
      logic [csup_pkg::CW-1:0] dif;
      logic [31:0] rd;
      wr_go = avs_write_i && !s_r.wait_r;
      start_wr = 1'b0;
      conf_wr = 1'b0;
      hm = avs_writedata_i[csup_pkg::SPAN_HOLD_LSB +: 6];
      dif = (conc_i >= s_r.gas) ? conc_i - s_r.gas : s_r.gas - conc_i;
      near = dif <= s_r.tol;
      rd = 32'h0;
      s_nxt = s_r;
      if (conc_vld_i)
         s_nxt.last_smp = conc_i;

      // Read mux; unmapped offsets read as zero
      case ({avs_address_i[5:2], 2'b00})
         csup_pkg::OFS_ALM1_CFG: rd = {28'h0, s_r.cfg1};
         csup_pkg::OFS_ALM1_SP: rd = {8'h0, s_r.sp1};
         csup_pkg::OFS_ALM2_CFG: rd = {28'h0, s_r.cfg2};
         csup_pkg::OFS_ALM2_SP: rd = {8'h0, s_r.sp2};
         csup_pkg::OFS_SPAN_CFG: rd = {18'h0, s_r.hold_min, 7'h0, s_r.auto_mode};
         csup_pkg::OFS_SPAN_GAS: rd = {8'h0, s_r.gas};
         csup_pkg::OFS_SPAN_TOL: rd = {8'h0, s_r.tol};
         csup_pkg::OFS_STATUS: rd = {25'h0, s_r.st, s_r.show, s_r.fail_flag, alarm2, alarm1};
         csup_pkg::OFS_SLOPE: rd = {{7{s_r.slope[csup_pkg::CW]}}, s_r.slope};
         csup_pkg::OFS_CAL: rd = {8'h0, s_r.cal};
         default: rd = 32'h0;
      endcase

      // One wait cycle, then the request completes
      if ((avs_read_i || avs_write_i) && s_r.wait_r)
      begin
         s_nxt.wait_r = 1'b0;
         s_nxt.rdata = rd;
      end
      else
      begin
         s_nxt.wait_r = 1'b1;
      end

      if (wr_go)
      begin
         case ({avs_address_i[5:2], 2'b00})
            csup_pkg::OFS_ALM1_CFG: s_nxt.cfg1 = avs_writedata_i[3:0];
            csup_pkg::OFS_ALM1_SP: s_nxt.sp1 = avs_writedata_i[csup_pkg::CW-1:0];
            csup_pkg::OFS_ALM2_CFG: s_nxt.cfg2 = avs_writedata_i[3:0];
            csup_pkg::OFS_ALM2_SP: s_nxt.sp2 = avs_writedata_i[csup_pkg::CW-1:0];
            csup_pkg::OFS_SPAN_CFG:
            begin
               s_nxt.auto_mode = avs_writedata_i[csup_pkg::SPAN_AUTO];
               if (hm < csup_pkg::HOLD_MIN_LO)
                  s_nxt.hold_min = csup_pkg::HOLD_MIN_LO;
               else if (hm > csup_pkg::HOLD_MIN_HI)
                  s_nxt.hold_min = csup_pkg::HOLD_MIN_HI;
               else
                  s_nxt.hold_min = hm;
            end
            csup_pkg::OFS_SPAN_GAS: s_nxt.gas = avs_writedata_i[csup_pkg::CW-1:0];
            csup_pkg::OFS_SPAN_TOL: s_nxt.tol = avs_writedata_i[csup_pkg::CW-1:0];
            csup_pkg::OFS_SPAN_CMD:
            begin
               start_wr = avs_writedata_i[csup_pkg::CMD_START];
               conf_wr = avs_writedata_i[csup_pkg::CMD_CONFIRM];
            end
            default: s_nxt.rdata = s_nxt.rdata;
         endcase
      end

      // Slope from successive samples at the fixed rate
      if (tick && (s_r.st == csup_pkg::ST_SETTLE || s_r.st == csup_pkg::ST_HOLD))
      begin
         s_nxt.slope = {1'b0, s_r.last_smp} - {1'b0, s_r.prev_smp};
         s_nxt.prev_smp = s_r.last_smp;
      end

      // Span sequence
      case (s_r.st)
         csup_pkg::ST_IDLE:
         begin
            if (start_wr)
            begin
               s_nxt.st = csup_pkg::ST_SETTLE;
               s_nxt.cal_prev = s_r.cal;
               s_nxt.prev_smp = s_r.last_smp;
               s_nxt.slope = 25'h0;
            end
         end
         csup_pkg::ST_SETTLE:
         begin
            if (s_r.auto_mode && conc_vld_i && near)
            begin
               s_nxt.st = csup_pkg::ST_HOLD;
               s_nxt.sec_cnt = 12'(s_r.hold_min) * 12'(csup_pkg::SEC_PER_MIN);
            end
            else if (!s_r.auto_mode && conf_wr)
               s_nxt.st = csup_pkg::ST_CHECK;
         end
         csup_pkg::ST_HOLD:
         begin
            if (tick)
            begin
               if (s_r.sec_cnt <= 12'h001)
                  s_nxt.st = csup_pkg::ST_CHECK;
               else
                  s_nxt.sec_cnt = s_r.sec_cnt - 12'h001;
            end
         end
         csup_pkg::ST_CHECK:
         begin
            if (raw_sens_i < csup_pkg::SENS_MIN_NA)
            begin
               s_nxt.cal = s_r.cal_prev;
               s_nxt.fail_flag = 1'b1;
               s_nxt.st = csup_pkg::ST_FAIL;
               s_nxt.sec_cnt = csup_pkg::FAIL_SHOW_S;
            end
            else
            begin
               s_nxt.cal = s_r.gas;
               s_nxt.fail_flag = 1'b0;
               s_nxt.st = csup_pkg::ST_IDLE;
            end
         end
         csup_pkg::ST_FAIL:
         begin
            if (tick)
            begin
               if (s_r.sec_cnt <= 12'h001)
                  s_nxt.st = csup_pkg::ST_IDLE;
               else
                  s_nxt.sec_cnt = s_r.sec_cnt - 12'h001;
            end
         end
         default: s_nxt.st = csup_pkg::ST_IDLE;
      endcase

      // System relay is failsafe: energized while healthy
      s_nxt.sys_relay = !s_nxt.fail_flag;
      s_nxt.busy = s_nxt.st != csup_pkg::ST_IDLE;
      s_nxt.show = s_nxt.st == csup_pkg::ST_FAIL;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
         s_r <= S_RST;
      else
         s_r <= s_nxt;
   end

   assign avs_readdata_o = s_r.rdata;
   assign avs_waitrequest_o = s_r.wait_r;
   assign cal_span_o = s_r.cal;
   assign sys_alarm_relay_o = s_r.sys_relay;
   assign span_fail_flag_o = s_r.fail_flag;
   assign span_fail_show_o = s_r.show;
   assign span_active_o = s_r.busy;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n);

   sequence seq_fail_enter;
      s_r.st == csup_pkg::ST_CHECK && raw_sens_i < csup_pkg::SENS_MIN_NA;
   endsequence

   sequence seq_manual_confirm;
      s_r.st == csup_pkg::ST_SETTLE && !s_r.auto_mode && avs_write_i && !s_r.wait_r &&
         {avs_address_i[5:2], 2'b00} == csup_pkg::OFS_SPAN_CMD && avs_writedata_i[csup_pkg::CMD_CONFIRM];
   endsequence

   a_high_trip: assert property (conc_vld_i && s_r.cfg1 == 4'h8 && conc_i > s_r.sp1
      |=> alarm1 && first_conc_alarm_relay_o)
      else $error("high alarm did not trip");

   a_low_fs: assert property (conc_vld_i && s_r.cfg2 == 4'h2 && conc_i < s_r.sp2
      |=> alarm2 && !second_conc_alarm_relay_o)
      else $error("low failsafe alarm wrong");

   a_defeat_quiet: assert property (s_r.cfg1[csup_pkg::CFG_DEFEAT] && $past(s_r.cfg1[csup_pkg::CFG_DEFEAT])
      |-> !alarm1)
      else $error("defeated alarm active");

   a_nolatch_clear: assert property (conc_vld_i && s_r.cfg1 == 4'h8 && conc_i <= s_r.sp1
      |=> !alarm1)
      else $error("non-latching alarm stuck");

   a_latch_hold: assert property (alarm1 && s_r.cfg1[csup_pkg::CFG_LATCH] && !s_r.cfg1[csup_pkg::CFG_DEFEAT]
      && !(avs_write_i && !s_r.wait_r) |=> alarm1)
      else $error("latched alarm dropped");

   a_fail_restore: assert property (seq_fail_enter |=> s_r.st == csup_pkg::ST_FAIL
      && s_r.cal == $past(s_r.cal_prev) && span_fail_flag_o && !sys_alarm_relay_o)
      else $error("failed span not restored");

   a_fail_show: assert property (seq_fail_enter |=> span_fail_show_o[*2])
      else $error("failure not shown");

   a_fail_sticky: assert property (span_fail_flag_o && s_r.st != csup_pkg::ST_CHECK |=> span_fail_flag_o)
      else $error("failure flag lost");

   a_manual_skip: assert property (seq_manual_confirm |=> s_r.st == csup_pkg::ST_CHECK ##1
      s_r.st != csup_pkg::ST_HOLD)
      else $error("manual span entered hold");

   a_good_span: assert property (s_r.st == csup_pkg::ST_CHECK && raw_sens_i >= csup_pkg::SENS_MIN_NA
      |=> cal_span_o == $past(s_r.gas) && !span_fail_flag_o && !span_active_o)
      else $error("good span not applied");

   a_hold_range: assert property (s_r.hold_min >= csup_pkg::HOLD_MIN_LO
      && s_r.hold_min <= csup_pkg::HOLD_MIN_HI)
      else $error("hold time out of range");

   a_slope_diff: assert property (tick && s_r.st == csup_pkg::ST_SETTLE
      |=> s_r.slope == $past({1'b0, s_r.last_smp}) - $past({1'b0, s_r.prev_smp}))
      else $error("slope wrong");
endmodule : csup_supervisor
`default_nettype wire

/* csup_pkg.sv */
package csup_pkg;
   // Data widths
   localparam int CW = 24;
   localparam int SW = 16;
   // Timing
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_S = 1;
   localparam int TICK_CYC = CLK_HZ * TICK_S;
   localparam int SEC_PER_MIN = 60;
   localparam logic [5:0] HOLD_MIN_LO = 6'h01;
   localparam logic [5:0] HOLD_MIN_HI = 6'h3c;
   localparam logic [5:0] HOLD_MIN_DEF = 6'h05;
   localparam logic [11:0] FAIL_SHOW_S = 12'h005;
   // Least sensitivity 0.5 uA/ppm, in nA/ppm
   localparam logic [SW-1:0] SENS_MIN_NA = 16'h01f4;
   // Register byte offsets
   localparam logic [5:0] OFS_ALM1_CFG = 6'h00;
   localparam logic [5:0] OFS_ALM1_SP = 6'h04;
   localparam logic [5:0] OFS_ALM2_CFG = 6'h08;
   localparam logic [5:0] OFS_ALM2_SP = 6'h0c;
   localparam logic [5:0] OFS_SPAN_CFG = 6'h10;
   localparam logic [5:0] OFS_SPAN_GAS = 6'h14;
   localparam logic [5:0] OFS_SPAN_TOL = 6'h18;
   localparam logic [5:0] OFS_SPAN_CMD = 6'h1c;
   localparam logic [5:0] OFS_STATUS = 6'h20;
   localparam logic [5:0] OFS_SLOPE = 6'h24;
   localparam logic [5:0] OFS_CAL = 6'h28;
   // Alarm configuration fields
   localparam int CFG_DEFEAT = 0;
   localparam int CFG_FAILSAFE = 1;
   localparam int CFG_LATCH = 2;
   localparam int CFG_DIR = 3;
   // Span configuration and command fields
   localparam int SPAN_AUTO = 0;
   localparam int SPAN_HOLD_LSB = 8;
   localparam int CMD_START = 0;
   localparam int CMD_CONFIRM = 1;
   // Status fields
   localparam int STS_ALM1 = 0;
   localparam int STS_ALM2 = 1;
   localparam int STS_FAIL = 2;
   localparam int STS_SHOW = 3;
   localparam int STS_ST_LSB = 4;
   // Reset values
   localparam logic [3:0] ALM_CFG_RST = 4'h0;
   localparam logic [CW-1:0] SP_RST = 24'h000000;
   localparam logic [CW-1:0] GAS_RST = 24'h000008;
   localparam logic [CW-1:0] TOL_RST = 24'h00000a;
   localparam logic [CW-1:0] CAL_RST = 24'h000000;
   // Span sequence
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_SETTLE = 3'b001,
      ST_HOLD = 3'b010,
      ST_CHECK = 3'b011,
      ST_FAIL = 3'b100
   } csup_span_st_t;
endpackage : csup_pkg

/* csup_tick.sv */
`timescale 1ns/1ns
`default_nettype none
module csup_tick #(
   parameter int unsigned CYC = 100
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Control
   input wire logic en_i,
   output logic tick_o
);
   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } csup_tick_state_t;

   csup_tick_state_t s_r;
   csup_tick_state_t s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (!en_i)
      begin
         s_nxt.cnt = 32'h0;
      end
      else if (s_r.cnt == CYC[31:0] - 32'h1)
      begin
         s_nxt.cnt = 32'h0;
         s_nxt.tick = 1'b1;
      end
      else
      begin
         s_nxt.cnt = s_r.cnt + 32'h1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         s_r <= '{cnt: 32'h0, tick: 1'b0};
      else
         s_r <= s_nxt;
   end

   assign tick_o = s_r.tick;
endmodule : csup_tick
`default_nettype wire

/* csup_alarm_unit.sv */
`timescale 1ns/1ns
`default_nettype none
module csup_alarm_unit (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Settings
   input wire logic [3:0] cfg_i,
   input wire logic [csup_pkg::CW-1:0] setpoint_i,
   // Samples
   input wire logic [csup_pkg::CW-1:0] conc_i,
   input wire logic conc_vld_i,
   // Results
   output logic alarm_o,
   output logic relay_o
);
   typedef struct packed {
      logic alarm;
      logic relay;
      logic latch_q;
   } csup_alm_state_t;

   csup_alm_state_t s_r;
   csup_alm_state_t s_nxt;
   logic trip;

   always_comb
   begin
      trip = cfg_i[csup_pkg::CFG_DIR] ? (conc_i > setpoint_i) : (conc_i < setpoint_i);
      s_nxt = s_r;
      s_nxt.latch_q = cfg_i[csup_pkg::CFG_LATCH];
      if (cfg_i[csup_pkg::CFG_DEFEAT])
         s_nxt.alarm = 1'b0;
      else if (s_r.latch_q && !cfg_i[csup_pkg::CFG_LATCH])
         s_nxt.alarm = 1'b0;
      else if (conc_vld_i)
         s_nxt.alarm = cfg_i[csup_pkg::CFG_LATCH] ? (s_r.alarm | trip) : trip;
      s_nxt.relay = cfg_i[csup_pkg::CFG_FAILSAFE] ? !s_nxt.alarm : s_nxt.alarm;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         s_r <= '{alarm: 1'b0, relay: 1'b0, latch_q: 1'b0};
      else
         s_r <= s_nxt;
   end

   assign alarm_o = s_r.alarm;
   assign relay_o = s_r.relay;
endmodule : csup_alarm_unit
`default_nettype wire

/* csup_sensor_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Measurement path: sample valid follows send one cycle later, sample bus scrambled between samples
module csup_sensor_model (
   // Clock
   input wire logic clk_sys_i,
   // Control from bench
   input wire logic send_i,
   input wire logic [csup_pkg::CW-1:0] val_i,
   input wire logic [csup_pkg::SW-1:0] sens_i,
   // Toward supervisor
   output logic [csup_pkg::CW-1:0] conc_o,
   output logic conc_vld_o,
   output logic [csup_pkg::SW-1:0] raw_sens_o
);
   initial
   begin
      conc_o = 24'h000000;
      conc_vld_o = 1'b0;
      raw_sens_o = 16'h0000;
   end
   always @(posedge clk_sys_i)
   begin
      conc_vld_o <= send_i;
      conc_o <= send_i ? val_i : ~conc_o;
      raw_sens_o <= sens_i;
   end
endmodule : csup_sensor_model
`default_nettype wire

/* tb_conc_alarm_span_supervisor.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_conc_alarm_span_supervisor;
   typedef struct packed {logic a; logic [3:0] cfg; logic [23:0] sp; logic [23:0] c; logic r;} csup_row_t;
   logic clk_sys_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic send = 1'b0;
   logic [23:0] val = 24'h000000;
   logic [15:0] sens = 16'h01f4;
   logic [23:0] conc;
   logic conc_vld;
   logic [15:0] raw_sens;
   logic [23:0] cal_span_o;
   logic rel1, rel2, sys_rel, flag, show, active;
   int fails = 0;
   int n_tests = 0;
   logic [31:0] rd;
   int n;
   csup_row_t rows[6] = '{
      {1'b0, 4'h8, 24'h000064, 24'h000096, 1'b1},
      {1'b0, 4'h8, 24'h000064, 24'h000032, 1'b0},
      {1'b1, 4'h0, 24'h000064, 24'h000032, 1'b1},
      {1'b1, 4'h2, 24'h000064, 24'h000032, 1'b0},
      {1'b1, 4'h2, 24'h000064, 24'h000096, 1'b1},
      {1'b0, 4'h9, 24'h000064, 24'h000096, 1'b0}};

   always #5 clk_sys_i = ~clk_sys_i;

   csup_sensor_model model (.clk_sys_i(clk_sys_i), .send_i(send), .val_i(val), .sens_i(sens),
      .conc_o(conc), .conc_vld_o(conc_vld), .raw_sens_o(raw_sens));

   csup_supervisor #(.TICK_CYC(4)) dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
      .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
      .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .conc_i(conc), .conc_vld_i(conc_vld),
      .raw_sens_i(raw_sens), .cal_span_o(cal_span_o), .first_conc_alarm_relay_o(rel1),
      .second_conc_alarm_relay_o(rel2), .sys_alarm_relay_o(sys_rel), .span_fail_flag_o(flag),
      .span_fail_show_o(show), .span_active_o(active));

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_sys_i);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      k = 0;
      do
      begin
         @(posedge clk_sys_i);
         k++;
      end
      while (avs_waitrequest_o !== 1'b0 && k < 50);
      rd = avs_readdata_o;
      if (k >= 50)
         chk("bus answer", 32'h1, 32'h0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic smp(input logic [23:0] v);
      @(posedge clk_sys_i);
      send <= 1'b1;
      val <= v;
      @(posedge clk_sys_i);
      send <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
   endtask : smp

   task automatic wait_idle(input int lim);
      n = 0;
      do
      begin
         @(posedge clk_sys_i);
         n++;
      end
      while (active !== 1'b0 && n < lim);
   endtask : wait_idle

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop

   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      fails++;
      report_and_stop();
   end

   initial
   begin
      repeat (5) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      chk("reset relays", 32'h2, {30'h0, sys_rel, rel1 | rel2 | flag});
      bus(1'b0, csup_pkg::OFS_SPAN_CFG, 32'h0);
      chk("span cfg reset", 32'h501, rd & 32'h3f01);
      bus(1'b0, 6'h3c, 32'h0);
      chk("unmapped read", 32'h0, rd);
      for (int i = 0; i < 6; i++)
      begin
         bus(1'b1, rows[i].a ? csup_pkg::OFS_ALM2_CFG : csup_pkg::OFS_ALM1_CFG, {28'h0, rows[i].cfg});
         bus(1'b1, rows[i].a ? csup_pkg::OFS_ALM2_SP : csup_pkg::OFS_ALM1_SP, {8'h0, rows[i].sp});
         smp(rows[i].c);
         chk("relay", {31'h0, rows[i].r}, {31'h0, rows[i].a ? rel2 : rel1});
         bus(1'b0, csup_pkg::OFS_STATUS, 32'h0);
         chk("status alarm", {31'h0, rows[i].r ^ rows[i].cfg[1]}, {31'h0, rd[rows[i].a]});
      end
      bus(1'b1, csup_pkg::OFS_ALM1_CFG, 32'hc);
      smp(24'h000096);
      smp(24'h000032);
      chk("latched", 32'h1, {31'h0, rel1});
      bus(1'b1, csup_pkg::OFS_ALM1_CFG, 32'h8);
      bus(1'b1, csup_pkg::OFS_ALM1_CFG, 32'hc);
      smp(24'h000032);
      chk("latch toggle", 32'h0, {31'h0, rel1});
      smp(24'h000096);
      bus(1'b1, csup_pkg::OFS_ALM1_CFG, 32'hd);
      bus(1'b1, csup_pkg::OFS_ALM1_CFG, 32'hc);
      smp(24'h000032);
      chk("defeat toggle", 32'h0, {31'h0, rel1});
      bus(1'b1, csup_pkg::OFS_SPAN_CFG, 32'h0);
      bus(1'b0, csup_pkg::OFS_SPAN_CFG, 32'h0);
      chk("hold low clamp", 32'h100, rd & 32'h3f00);
      bus(1'b1, csup_pkg::OFS_SPAN_CFG, 32'h3d01);
      bus(1'b0, csup_pkg::OFS_SPAN_CFG, 32'h0);
      chk("hold high clamp", 32'h3c00, rd & 32'h3f00);
      bus(1'b1, csup_pkg::OFS_SPAN_CFG, 32'h101);
      bus(1'b1, csup_pkg::OFS_SPAN_CMD, 32'h1);
      smp(24'h000012);
      wait_idle(400);
      chk("auto hold span", 32'h1, {31'h0, n >= 230 && n < 400});
      chk("auto cal", 32'h8, {8'h0, cal_span_o});
      sens <= 16'h01f3;
      bus(1'b1, csup_pkg::OFS_SPAN_GAS, 32'h64);
      bus(1'b1, csup_pkg::OFS_SPAN_CFG, 32'h3c00);
      bus(1'b1, csup_pkg::OFS_SPAN_CMD, 32'h1);
      // Ramp of one ppm per cycle while settling: four cycles per slope sample
      fork
         repeat (16)
         begin
            @(posedge clk_sys_i);
            send <= 1'b1;
            val <= val + 24'h000001;
         end
         begin
            repeat (10) @(posedge clk_sys_i);
            bus(1'b0, csup_pkg::OFS_SLOPE, 32'h0);
         end
      join
      @(posedge clk_sys_i);
      send <= 1'b0;
      chk("slope ramp", 32'h4, rd);
      bus(1'b1, csup_pkg::OFS_SPAN_CMD, 32'h2);
      n = 0;
      repeat (100)
      begin
         @(posedge clk_sys_i);
         if (show === 1'b1)
            n++;
      end
      chk("show span", 32'h1, {31'h0, n >= 16 && n <= 24});
      chk("fail outputs", 32'h2, {30'h0, flag, sys_rel | active});
      chk("cal restored", 32'h8, {8'h0, cal_span_o});
      repeat (200) @(posedge clk_sys_i);
      chk("flag kept", 32'h1, {31'h0, flag});
      sens <= 16'h01f4;
      bus(1'b1, csup_pkg::OFS_SPAN_CMD, 32'h1);
      bus(1'b1, csup_pkg::OFS_SPAN_CMD, 32'h2);
      wait_idle(10);
      chk("manual quick", 32'h1, {31'h0, n < 10});
      chk("manual cal", 32'h64, {8'h0, cal_span_o});
      chk("flag cleared", 32'h1, {30'h0, flag, sys_rel});
      // Fail once more, then a power cycle must clear the flag
      sens <= 16'h01f3;
      bus(1'b1, csup_pkg::OFS_SPAN_CMD, 32'h1);
      bus(1'b1, csup_pkg::OFS_SPAN_CMD, 32'h2);
      wait_idle(100);
      chk("fail again", 32'h2, {30'h0, flag, sys_rel});
      arst_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      chk("power cycle", 32'h2, {30'h0, sys_rel, rel1 | rel2 | flag});
      chk("cal after reset", 32'h0, {8'h0, cal_span_o});
      report_and_stop();
   end
endmodule : tb_conc_alarm_span_supervisor
`default_nettype wire
